/* File: common/nwp_cfg.svh */
// Offsets, field positions, reset values and timing counts of the NVM protection block
`ifndef NWP_CFG_SVH
`define NWP_CFG_SVH
// Printed offsets are not multiples of four: these are indices, byte address = 4 * index
`define NWP_IDX_CTRL1 16'h505a
`define NWP_IDX_CTRL2 16'h505b
`define NWP_IDX_CTRL2_INV 16'h505c
`define NWP_IDX_BOOT_PROT 16'h505d
`define NWP_IDX_BOOT_PROT_INV 16'h505e
`define NWP_IDX_STATUS 16'h505f
`define NWP_IDX_PM_KEY 16'h5062
`define NWP_IDX_EE_KEY 16'h5064
`define NWP_IDX_IRQ_MASK 16'h5066
`define NWP_IDX_BASE 16'h5000
`define NWP_RST_CTRL1 8'h00
`define NWP_RST_CTRL2 8'h00
`define NWP_RST_CTRL2_INV 8'hff
`define NWP_RST_BOOT_PROT 8'h00
`define NWP_RST_BOOT_PROT_INV 8'hff
`define NWP_RST_STATUS 8'h00
`define NWP_RST_KEY 8'h00
// Key sequence bytes
`define NWP_KEY_FIRST 8'h56
`define NWP_KEY_SECOND 8'hae
`define NWP_KEY_DATA_FIRST 8'hae
`define NWP_KEY_DATA_SECOND 8'h56
// Control 1 fields
`define NWP_C1_ACTIVE_HALT_POWER_DOWN_PD 3
// Control 2 fields
`define NWP_C2_PROG 0
// Status fields
`define NWP_ST_WR_REFUSED 0
`define NWP_ST_PM_UNLOCKED 1
`define NWP_ST_EOP 2
`define NWP_ST_EE_UNLOCKED 3
`define NWP_ST_BUSY 4
// Page size of the boot-code area in bytes, and its log2
`define NWP_PAGE_BYTES 64
`define NWP_PAGE_SHIFT 6
// EEPROM write time in ns and the derived cycle count at 4 ns
`define NWP_EE_WRITE_NS 3000
`define NWP_CLK_NS 4
`define NWP_EE_WRITE_CYC ((`NWP_EE_WRITE_NS + `NWP_CLK_NS - 1) / `NWP_CLK_NS)
`endif

/* File: common/nwp_pkg.sv */
// Types for the NVM protection block
package nwp_pkg;
   typedef enum logic [1:0] {
      NWP_AREA_PROG,
      NWP_AREA_EEPROM,
      NWP_AREA_OPTION,
      NWP_AREA_NONE
   } nwp_area_e;
   typedef struct packed {
      logic req;
      nwp_area_e area;
      logic [12:0] addr;
      logic [7:0] data;
   } nwp_wr_s;
   typedef enum logic [1:0] {
      NWP_LK_LOCKED,
      NWP_LK_FIRST_OK,
      NWP_LK_OPEN
   } nwp_lock_e;
endpackage

/* File: design/nwp_ctrl.sv */
// NVM write-protection control logic with APB register bank
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "nwp_cfg.svh"
// Operation
// R01: After reset all writes to program, EEPROM and option bytes are refused.
// R02: Correct two-byte key into an unlock register opens that area for writes.
// R03: Boot-code area stays write-protected even with program memory unlocked.
// R04: Boot-area size in 64-byte pages; option write only in in-circuit mode.
// R05: No array reads are served while an EEPROM write is in progress.
// R06: Control 1 and 2 reset to 0x00, control 2 inverse to 0xff.
// R07: Protection resets to 0x00, its inverse to 0xff.
// R08: Separate program and EEPROM key registers at own addresses, reset 0x00.
// R09: Status register resets to 0x00 and shows unlock and programming state.
// R10: Control 1 bit selects memory power-down during active-halt.
// R11: Control 2 only takes effect once its inverse is written consistently; ctrl2_act_ff holds the checked value but drives no output.
module nwp_ctrl
   import nwp_pkg::*;
#(
   parameter int EE_WRITE_CYC = `NWP_EE_WRITE_CYC
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Array write requests from the CPU side
   input wire nwp_wr_s wr_in,
   output nwp_wr_s wr_out,
   // Array read gating
   input wire logic rd_req,
   output logic rd_grant,
   // Mode and option inputs
   input wire logic in_circuit_programming_mode,
   input wire logic [7:0] boot_code_area_opt,
   // Power and interrupt
   output logic active_halt_power_down,
   output logic irq
);
   // Registers
   logic [7:0] ctrl1_ff, nxt_ctrl1;
   logic [7:0] ctrl2_ff, nxt_ctrl2;
   logic [7:0] ctrl2_inv_ff, nxt_ctrl2_inv;
   logic [7:0] ctrl2_act_ff, nxt_ctrl2_act;
   logic [7:0] prot_ff, nxt_prot;
   logic [7:0] prot_inv_ff, nxt_prot_inv;
   logic [7:0] status_ff, nxt_status;
   logic [7:0] mask_ff, nxt_mask;
   logic [7:0] pm_key_ff, nxt_pm_key;
   logic [7:0] ee_key_ff, nxt_ee_key;
   nwp_lock_e pm_lk_ff, nxt_pm_lk;
   nwp_lock_e ee_lk_ff, nxt_ee_lk;
   logic [31:0] busy_cnt_ff, nxt_busy_cnt;
   nwp_wr_s wr_out_ff, nxt_wr_out;
   logic [31:0] prdata_ff, nxt_prdata;
   logic opt_load_ff, nxt_opt_load;

   // Address decode: printed offsets are indices, byte address is four times
   wire logic acc = psel & penable;
   wire logic wr_acc = acc & pwrite & pstrb[0];
   wire logic [13:0] widx = paddr[15:2];
   wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[31:16] == 16'h0001);
   wire logic [15:0] idx = {2'b01, widx};
   wire logic hit_c1 = aligned && (idx == `NWP_IDX_CTRL1);
   wire logic hit_c2 = aligned && (idx == `NWP_IDX_CTRL2);
   wire logic hit_c2i = aligned && (idx == `NWP_IDX_CTRL2_INV);
   wire logic hit_fp = aligned && (idx == `NWP_IDX_BOOT_PROT);
   wire logic hit_fpi = aligned && (idx == `NWP_IDX_BOOT_PROT_INV);
   wire logic hit_st = aligned && (idx == `NWP_IDX_STATUS);
   wire logic hit_pk = aligned && (idx == `NWP_IDX_PM_KEY);
   wire logic hit_ek = aligned && (idx == `NWP_IDX_EE_KEY);
   wire logic hit_mk = aligned && (idx == `NWP_IDX_IRQ_MASK);
   wire logic hit_any = hit_c1 | hit_c2 | hit_c2i | hit_fp | hit_fpi | hit_st | hit_pk
      | hit_ek | hit_mk;
   wire logic [7:0] wb = pwdata[7:0];

   // Protection state seen by the write gate
   wire logic pm_open = (pm_lk_ff == NWP_LK_OPEN);
   wire logic ee_open = (ee_lk_ff == NWP_LK_OPEN);
   wire logic ee_busy = status_ff[`NWP_ST_BUSY];
   // Boot area end in bytes: pages of 64 bytes
   wire logic [14:0] boot_end = {1'b0, prot_ff, 6'h00};
   wire logic in_boot = ({2'b00, wr_in.addr} < boot_end); // [R03] [R04]

   // Write gate: base lock first, then boot area, then busy array
   wire logic allow_prog = pm_open && !in_boot; // [R01] [R02] [R03]
   wire logic allow_ee = ee_open && !ee_busy; // [R01] [R02]
   wire logic allow_opt = pm_open && in_circuit_programming_mode; // [R04]
   wire logic allow_wr = wr_in.req && (
      (wr_in.area == NWP_AREA_PROG && allow_prog) ||
      (wr_in.area == NWP_AREA_EEPROM && allow_ee) ||
      (wr_in.area == NWP_AREA_OPTION && allow_opt));
   wire logic refused = wr_in.req && !allow_wr; // [R01]
   wire logic ee_start = allow_wr && (wr_in.area == NWP_AREA_EEPROM);
   wire logic busy_done = ee_busy && (busy_cnt_ff == 32'h00000001);

   // Reads refused while the EEPROM write runs, no read during write
   assign rd_grant = rd_req && !ee_busy; // [R05]

   // Complementary pair check on control 2
   wire logic c2_pair_ok = (ctrl2_ff == ~ctrl2_inv_ff); // [R11]

   // Key sequence engine, one for program memory and one for EEPROM
   always_comb begin
      nxt_pm_lk = pm_lk_ff;
      nxt_ee_lk = ee_lk_ff;
      if (wr_acc && hit_pk) begin
         case (pm_lk_ff)
            NWP_LK_LOCKED: nxt_pm_lk = (wb == `NWP_KEY_FIRST) ? NWP_LK_FIRST_OK : NWP_LK_LOCKED;
            NWP_LK_FIRST_OK: nxt_pm_lk = (wb == `NWP_KEY_SECOND) ? NWP_LK_OPEN : NWP_LK_LOCKED;
            NWP_LK_OPEN: nxt_pm_lk = NWP_LK_OPEN;
            default: nxt_pm_lk = NWP_LK_LOCKED;
         endcase // [R02] [R08]
      end
      if (wr_acc && hit_ek) begin
         case (ee_lk_ff)
            NWP_LK_LOCKED: nxt_ee_lk = (wb == `NWP_KEY_DATA_FIRST) ? NWP_LK_FIRST_OK :
               NWP_LK_LOCKED;
            NWP_LK_FIRST_OK: nxt_ee_lk = (wb == `NWP_KEY_DATA_SECOND) ? NWP_LK_OPEN :
               NWP_LK_LOCKED;
            NWP_LK_OPEN: nxt_ee_lk = NWP_LK_OPEN;
            default: nxt_ee_lk = NWP_LK_LOCKED;
         endcase // [R02] [R08]
      end
      // Clearing the unlocked status bit relocks the area
      if (wr_acc && hit_st && !wb[`NWP_ST_PM_UNLOCKED]) begin
         nxt_pm_lk = NWP_LK_LOCKED;
      end
      if (wr_acc && hit_st && !wb[`NWP_ST_EE_UNLOCKED]) begin
         nxt_ee_lk = NWP_LK_LOCKED;
      end
   end

   // Register writes
   always_comb begin
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      nxt_ctrl2_inv = ctrl2_inv_ff;
      nxt_ctrl2_act = c2_pair_ok ? ctrl2_ff : ctrl2_act_ff; // [R11]
      nxt_mask = mask_ff;
      nxt_pm_key = (wr_acc && hit_pk) ? wb : pm_key_ff;
      nxt_ee_key = (wr_acc && hit_ek) ? wb : ee_key_ff;
      if (wr_acc && hit_c1) begin
         nxt_ctrl1 = wb; // [R10]
      end
      if (wr_acc && hit_c2) begin
         nxt_ctrl2 = wb;
      end
      if (wr_acc && hit_c2i) begin
         nxt_ctrl2_inv = wb;
      end
      if (wr_acc && hit_mk) begin
         nxt_mask = wb;
      end
   end

   // Option load: protection pair captured one cycle after reset release
   assign nxt_opt_load = 1'b1;
   assign nxt_prot = opt_load_ff ? prot_ff : boot_code_area_opt; // [R04]
   assign nxt_prot_inv = opt_load_ff ? prot_inv_ff : ~boot_code_area_opt; // [R07]

   // EEPROM write timer; busy blocks array reads and further EEPROM writes
   always_comb begin
      nxt_busy_cnt = busy_cnt_ff;
      if (ee_start) begin
         nxt_busy_cnt = EE_WRITE_CYC;
      end else if (ee_busy) begin
         nxt_busy_cnt = busy_cnt_ff - 32'h00000001;
      end
   end

   // Status: sticky events, set wins over write-one-to-clear
   wire logic [7:0] st_set = {3'b000, ee_start, 1'b0, busy_done, 1'b0, refused};
   wire logic [7:0] st_w1c = (wr_acc && hit_st) ? (wb & 8'h05) : 8'h00;
   always_comb begin
      nxt_status = (status_ff & ~st_w1c) | st_set;
      nxt_status[`NWP_ST_BUSY] = ee_start || (ee_busy && !busy_done); // [R05]
      nxt_status[`NWP_ST_PM_UNLOCKED] = (nxt_pm_lk == NWP_LK_OPEN); // [R09]
      nxt_status[`NWP_ST_EE_UNLOCKED] = (nxt_ee_lk == NWP_LK_OPEN); // [R09]
      nxt_status[7:5] = 3'b000;
      nxt_status[1] = (nxt_pm_lk == NWP_LK_OPEN);
   end

   // Forward only accepted writes to the array
   always_comb begin
      nxt_wr_out = wr_in;
      nxt_wr_out.req = allow_wr; // [R01] [R03]
   end

   // Read mux
   wire logic [7:0] rd_byte =
      hit_c1 ? ctrl1_ff :
      hit_c2 ? ctrl2_ff :
      hit_c2i ? ctrl2_inv_ff :
      hit_fp ? prot_ff :
      hit_fpi ? prot_inv_ff :
      hit_st ? status_ff :
      hit_pk ? pm_key_ff :
      hit_ek ? ee_key_ff :
      hit_mk ? mask_ff : 8'h00;
   assign nxt_prdata = (acc && !pwrite) ? {24'h000000, rd_byte} : prdata_ff;

   // Registers: one-cycle access phase, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_ff <= `NWP_RST_CTRL1; // [R06]
         ctrl2_ff <= `NWP_RST_CTRL2; // [R06]
         ctrl2_inv_ff <= `NWP_RST_CTRL2_INV; // [R06]
         ctrl2_act_ff <= `NWP_RST_CTRL2;
         prot_ff <= `NWP_RST_BOOT_PROT; // [R07]
         prot_inv_ff <= `NWP_RST_BOOT_PROT_INV; // [R07]
         status_ff <= `NWP_RST_STATUS; // [R09]
         mask_ff <= 8'h00;
         pm_key_ff <= `NWP_RST_KEY; // [R08]
         ee_key_ff <= `NWP_RST_KEY; // [R08]
         pm_lk_ff <= NWP_LK_LOCKED; // [R01]
         ee_lk_ff <= NWP_LK_LOCKED; // [R01]
         busy_cnt_ff <= 32'h00000000;
         wr_out_ff <= '0;
         prdata_ff <= 32'h00000000;
         opt_load_ff <= 1'b0;
      end else begin
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         ctrl2_inv_ff <= nxt_ctrl2_inv;
         ctrl2_act_ff <= nxt_ctrl2_act;
         prot_ff <= nxt_prot;
         prot_inv_ff <= nxt_prot_inv;
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         pm_key_ff <= nxt_pm_key;
         ee_key_ff <= nxt_ee_key;
         pm_lk_ff <= nxt_pm_lk;
         ee_lk_ff <= nxt_ee_lk;
         busy_cnt_ff <= nxt_busy_cnt;
         wr_out_ff <= nxt_wr_out;
         prdata_ff <= nxt_prdata;
         opt_load_ff <= nxt_opt_load;
      end
   end

   // Outputs
   assign pready = 1'b1; // Zero wait states keeps the CPU side simple
   assign pslverr = acc && !hit_any;
   assign prdata = prdata_ff;
   assign wr_out = wr_out_ff;
   assign active_halt_power_down = ctrl1_ff[`NWP_C1_ACTIVE_HALT_POWER_DOWN_PD]; // [R10]
   assign irq = |(status_ff & mask_ff & 8'h05);
endmodule // nwp_ctrl

/* File: verification/nwp_ctrl_monitor.sv */
// Property checker bound to the NVM protection block
`timescale 1ns/1ps
`include "nwp_cfg.svh"
module nwp_ctrl_monitor
   import nwp_pkg::*;
#(
   parameter int EE_WRITE_CYC = `NWP_EE_WRITE_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Array side
   input wire nwp_wr_s wr_in,
   input wire nwp_wr_s wr_out,
   input wire logic rd_req,
   input wire logic rd_grant,
   // Modes, power, interrupt
   input wire logic in_circuit_programming_mode,
   input wire logic [7:0] boot_code_area_opt,
   input wire logic active_halt_power_down,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase decode
   wire logic acc = psel && penable;
   wire logic c1_wr = acc && pwrite && pstrb[0] && paddr == {14'h0, `NWP_IDX_CTRL1, 2'b00};
   wire logic prot_rd = acc && !pwrite && paddr == {14'h0, `NWP_IDX_BOOT_PROT, 2'b00};
   wire logic hole = acc && paddr == {14'h0, 16'h5060, 2'b00};
   zero_wait_a:
      assert property (acc |-> pready) else $error("access without pready");
   hole_err_a:
      assert property (hole |-> pslverr) else $error("reserved index not refused");
   copy_ok_a:
      assert property (wr_out.req |-> $past(wr_in.req) && wr_out.data == $past(wr_in.data))
      else $error("array write passed without request");
   boot_guard_a:
      assert property (wr_in.req && wr_in.area == NWP_AREA_PROG
         && {1'b0, wr_in.addr} < {boot_code_area_opt, 6'h0} |=> !wr_out.req)
      else $error("boot area write passed");
   opt_icp_a:
      assert property (wr_in.req && wr_in.area == NWP_AREA_OPTION
         && !in_circuit_programming_mode |=> !wr_out.req)
      else $error("option write outside programming mode");
   ee_busy_a:
      assert property (wr_out.req && wr_out.area == NWP_AREA_EEPROM |=> !rd_grant)
      else $error("read granted during eeprom write");
   grant_req_a:
      assert property (rd_grant |-> rd_req) else $error("grant without request");
   prot_read_a:
      assert property (prot_rd |=> prdata[7:0] == boot_code_area_opt)
      else $error("protection size differs from option");
   halt_bit_a:
      assert property ($changed(active_halt_power_down) |-> $past(c1_wr) || $past(c1_wr, 2))
      else $error("power-down select moved without write");
endmodule // nwp_ctrl_monitor

bind nwp_ctrl nwp_ctrl_monitor #(.EE_WRITE_CYC(EE_WRITE_CYC)) nwp_ctrl_monitor_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .wr_in(wr_in), .wr_out(wr_out), .rd_req(rd_req), .rd_grant(rd_grant),
   .in_circuit_programming_mode(in_circuit_programming_mode),
   .boot_code_area_opt(boot_code_area_opt),
   .active_halt_power_down(active_halt_power_down), .irq(irq));

/* File: verification/nwp_ctrl_test.sv */
// Directed register and array-write tests for the NVM protection block
`timescale 1ns/1ps
`include "nwp_cfg.svh"
module nwp_ctrl_test;
   import nwp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_req = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, rd_grant, active_halt_power_down, irq, err, got;
   logic in_circuit_programming_mode = 1'b0;
   logic [7:0] boot_code_area_opt = 8'h00;
   nwp_wr_s wr_in = '0, wr_out;
   int n_fail = 0, n_checks = 0, i;
   // Short EEPROM write keeps the run brief
   nwp_ctrl #(.EE_WRITE_CYC(8)) nwp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_in(wr_in), .wr_out(wr_out),
      .rd_req(rd_req), .rd_grant(rd_grant),
      .in_circuit_programming_mode(in_circuit_programming_mode),
      .boot_code_area_opt(boot_code_area_opt),
      .active_halt_power_down(active_halt_power_down), .irq(irq));
   always #2 pclk = ~pclk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; slave may stretch the access phase
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1 rd = prdata;
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] e, input string nm);
      apb(1'b0, idx, 8'h00);
      chk(nm, rd, {24'h0, e});
   endtask
   // Array write; accepted if it shows on the output within two cycles
   task automatic arr(input nwp_area_e a, input logic [12:0] ad, input logic ok, input string nm);
      @(posedge pclk);
      wr_in <= '{1'b1, a, ad, 8'h5a};
      @(posedge pclk);
      wr_in.req <= 1'b0;
      #1 got = wr_out.req;
      @(posedge pclk);
      #1 got = got | wr_out.req;
      chk(nm, {31'h0, got}, {31'h0, ok});
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard, far beyond the fewer than 200 cycles the tests need
   initial begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`NWP_IDX_CTRL1, 8'h00, "ctrl1");
      rchk(`NWP_IDX_CTRL2, 8'h00, "ctrl2");
      rchk(`NWP_IDX_CTRL2_INV, 8'hff, "ctrl2 inv");
      rchk(`NWP_IDX_BOOT_PROT, 8'h00, "prot");
      rchk(`NWP_IDX_BOOT_PROT_INV, 8'hff, "prot inv");
      rchk(`NWP_IDX_STATUS, 8'h00, "status");
      rchk(`NWP_IDX_PM_KEY, 8'h00, "pm key");
      rchk(`NWP_IDX_EE_KEY, 8'h00, "ee key");
      apb(1'b0, 16'h5060, 8'h00);
      chk("hole err", {31'h0, err}, 32'h1);
      // Second reset with a two-page boot area
      @(posedge pclk);
      presetn <= 1'b0;
      boot_code_area_opt <= 8'h02;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`NWP_IDX_BOOT_PROT_INV, 8'hfd, "prot inv opt");
      rchk(`NWP_IDX_BOOT_PROT, 8'h02, "prot opt");
      arr(NWP_AREA_PROG, 13'h1000, 1'b0, "locked prog");
      arr(NWP_AREA_EEPROM, 13'h0000, 1'b0, "locked ee");
      rchk(`NWP_IDX_STATUS, 8'h01, "refused flag");
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, `NWP_IDX_IRQ_MASK, 8'h05);
      chk("irq on", {31'h0, irq}, 32'h1);
      apb(1'b1, `NWP_IDX_STATUS, 8'h01);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      // Broken key sequence stays locked
      apb(1'b1, `NWP_IDX_PM_KEY, `NWP_KEY_FIRST);
      apb(1'b1, `NWP_IDX_PM_KEY, 8'h00);
      apb(1'b1, `NWP_IDX_PM_KEY, `NWP_KEY_SECOND);
      rchk(`NWP_IDX_STATUS, 8'h00, "bad key");
      apb(1'b1, `NWP_IDX_PM_KEY, `NWP_KEY_FIRST);
      apb(1'b1, `NWP_IDX_PM_KEY, `NWP_KEY_SECOND);
      rchk(`NWP_IDX_STATUS, 8'h02, "pm open");
      arr(NWP_AREA_PROG, 13'h1000, 1'b1, "open prog");
      arr(NWP_AREA_PROG, 13'h007f, 1'b0, "boot top");
      arr(NWP_AREA_PROG, 13'h0080, 1'b1, "above boot");
      arr(NWP_AREA_OPTION, 13'h0000, 1'b0, "opt no icp");
      in_circuit_programming_mode <= 1'b1;
      arr(NWP_AREA_OPTION, 13'h0000, 1'b1, "opt icp");
      // Keep bit1 high so the program area stays unlocked while bit0 clears
      apb(1'b1, `NWP_IDX_STATUS, 8'h03);
      apb(1'b1, `NWP_IDX_EE_KEY, `NWP_KEY_DATA_FIRST);
      apb(1'b1, `NWP_IDX_EE_KEY, `NWP_KEY_DATA_SECOND);
      rchk(`NWP_IDX_STATUS, 8'h0a, "ee open");
      // Reads held off while the EEPROM write runs
      arr(NWP_AREA_EEPROM, 13'h027f, 1'b1, "ee write");
      rd_req <= 1'b1;
      @(posedge pclk);
      #1 chk("grant busy", {31'h0, rd_grant}, 32'h0);
      for (i = 0; i < 40 && rd_grant !== 1'b1; i++) @(posedge pclk);
      chk("grant after", {31'h0, rd_grant}, 32'h1);
      rchk(`NWP_IDX_STATUS, 8'h0e, "ee done");
      chk("irq done", {31'h0, irq}, 32'h1);
      // Complementary pair written as software must
      apb(1'b1, `NWP_IDX_CTRL2, 8'h01);
      apb(1'b1, `NWP_IDX_CTRL2_INV, 8'hfe);
      rchk(`NWP_IDX_CTRL2, 8'h01, "ctrl2 pair");
      rchk(`NWP_IDX_CTRL2_INV, 8'hfe, "ctrl2 inv pair");
      apb(1'b1, `NWP_IDX_CTRL1, 8'h08);
      repeat (2) @(posedge pclk);
      chk("halt pd", {31'h0, active_halt_power_down}, 32'h1);
      tally_and_finish();
   end
endmodule // nwp_ctrl_test
